// ==== nrf_pkg.sv ====
// Package with constants, types and register map for the NAND feature/reset host controller.
package nrf_pkg;
  // NAND command codes.
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam logic [7:0] CMD_GET_FEAT   = 8'hee;
  localparam logic [7:0] CMD_SET_FEAT   = 8'hef;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_READ_MODE  = 8'h00;
  // Feature addresses and parameter layout.
  localparam logic [7:0] FEAT_DRIVE     = 8'h80;
  localparam logic [7:0] FEAT_PULLDOWN  = 8'h81;
  localparam logic [7:0] FEAT_DEFAULT   = 8'h00;
  localparam int         FEAT_BYTES     = 4;
  localparam int         STRENGTH_LSB   = 0;
  localparam int         STRENGTH_W     = 2;
  // Status register bits and post-reset values.
  localparam int         SR_FAIL_BIT    = 0;
  localparam int         SR_WP_BIT      = 7;
  localparam int         SR_RDY_BIT     = 6;
  localparam int         SR_ARDY_BIT    = 5;
  localparam logic [7:0] SR_RST_WP_HI   = 8'he0;
  localparam logic [7:0] SR_RST_WP_LO   = 8'h60;
  // Avalon register byte offsets.
  localparam logic [4:0] REG_CTRL       = 5'h00;
  localparam logic [4:0] REG_STATUS     = 5'h04;
  localparam logic [4:0] REG_FEAT_ADDR  = 5'h08;
  localparam logic [4:0] REG_WDATA      = 5'h0c;
  localparam logic [4:0] REG_RDATA      = 5'h10;
  localparam logic [4:0] REG_NAND_SR    = 5'h14;
  // Control register fields: bit 0 starts, bits 2:1 select the operation, bit 3 drives protect.
  localparam int         CTRL_GO_BIT    = 0;
  localparam int         CTRL_OP_LSB    = 1;
  localparam int         CTRL_WP_BIT    = 3;
  localparam logic [1:0] OP_RESET       = 2'h0;
  localparam logic [1:0] OP_GET         = 2'h1;
  localparam logic [1:0] OP_SET         = 2'h2;
  localparam logic [1:0] OP_STATUS      = 2'h3;
  // Timing at 125 MHz.
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         PULSE_TIME_NS  = 25;
  localparam int         PULSE_CYC      = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PROTECT_SETUP_TIME_NS = 100;
  localparam int         PROTECT_CYC    =
    (PROTECT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         BUSY_WAIT_NS   = 200;
  localparam int         BUSY_WAIT_CYC  = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus cycle to the pin sequencer.
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       rd;
    logic [7:0] data;
  } nrf_cycle_t;

  // Pin bundle driven toward the memory.
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nrf_pins_t;
endpackage

// ==== nrf_sync.sv ====
`timescale 1ns/100ps
// Three-stage input synchroniser that accepts a change once stages two and three agree.
module nrf_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Data.
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Stages start at the idle high level of the pin, so no false change follows reset.
      s1_r   <= '1;
      s2_r   <= '1;
      s3_r   <= '1;
      o_sync <= '1;
    end
    else if (i_ce)
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
          o_sync[i] <= s3_r[i];
      end
    end
  end
endmodule

// ==== nrf_cycle.sv ====
`timescale 1ns/100ps
// Pin sequencer: plays one command, address, data-in or data-out cycle on the NAND strobes.
module nrf_cycle (
  // Clock and reset.
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // Cycle request.
  input  wire logic                i_start,
  input  wire nrf_pkg::nrf_cycle_t i_cyc,
  output logic                     o_done,
  output logic [7:0]               o_rdata,
  // Pins.
  output logic                     o_cle,
  output logic                     o_ale,
  output logic                     o_we_n,
  output logic                     o_read_strobe_n,
  output logic [7:0]               o_io_out,
  output logic                     o_io_oe,
  input  wire logic [7:0]          i_io_in
);
  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} nrf_cy_t;
  nrf_cy_t     st_r;
  logic [3:0]  cnt_r;
  logic        rd_r;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r            <= CY_IDLE;
      cnt_r           <= 4'h0;
      rd_r            <= 1'b0;
      o_done          <= 1'b0;
      o_rdata         <= 8'h00;
      o_cle           <= 1'b0;
      o_ale           <= 1'b0;
      o_we_n          <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_io_out        <= 8'h00;
      o_io_oe         <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      case (st_r)
        CY_IDLE:
        begin
          if (i_start)
          begin
            rd_r            <= i_cyc.rd;
            o_cle           <= i_cyc.cle;
            o_ale           <= i_cyc.ale;
            o_io_out        <= i_cyc.data;
            o_io_oe         <= ~i_cyc.rd;
            o_we_n          <= i_cyc.rd;
            o_read_strobe_n <= ~i_cyc.rd;
            cnt_r           <= 4'(nrf_pkg::PULSE_CYC);
            st_r            <= CY_LOW;
          end
        end
        CY_LOW:
        begin
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            // Data is latched by the memory on the rising write strobe.
            o_we_n          <= 1'b1;
            o_read_strobe_n <= 1'b1;
            if (rd_r)
              o_rdata <= i_io_in;
            cnt_r <= 4'(nrf_pkg::PULSE_CYC);
            st_r  <= CY_HIGH;
          end
        end
        CY_HIGH:
        begin
          if (cnt_r > 4'h1)
            cnt_r <= cnt_r - 4'h1;
          else
          begin
            o_cle   <= 1'b0;
            o_ale   <= 1'b0;
            o_io_oe <= 1'b0;
            o_done  <= 1'b1;
            st_r    <= CY_IDLE;
          end
        end
        default:
          st_r <= CY_IDLE;
      endcase
    end
  end
endmodule

// ==== nrf_ctrl.sv ====
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
// Host controller for NAND reset, get/set features and status, with Avalon-MM registers.

// Behaviour
// - Feature commands EEh and EFh take one feature address byte.
// - Feature read: EEh, address, wait ready, then read parameters.
// - After polling status during feature read, issue 00h before reading data.
// - Feature write: EFh, address, four bytes, then busy while storing.
// - Host holds write-protect steady until the operation completes.
module nrf_ctrl (
  // Clock, reset and enable.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Avalon-MM slave.
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // NAND pins.
  output logic             o_ce_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_we_n,
  output logic             o_read_strobe_n,
  output logic             o_wp_n,
  output logic [7:0]       o_io_out,
  output logic             o_io_oe,
  input  wire logic [7:0]  i_io_in,
  input  wire logic        i_ready_busy_n
);
  typedef enum logic [3:0] {
    S_IDLE, S_WP, S_CMD, S_ADDR, S_WDATA, S_WAIT_LO, S_WAIT_HI,
    S_RESUME, S_RDATA, S_STATUS
  } nrf_state_t;

  nrf_state_t          st_r;
  logic [1:0]          op_r;
  logic                wp_level_r;
  logic [7:0]          feat_addr_r;
  logic [31:0]         wdata_r;
  logic [31:0]         rdata_r;
  logic [7:0]          nand_sr_r;
  logic [1:0]          idx_r;
  logic [7:0]          wait_r;
  logic                busy_r;
  logic                done_r;
  logic                stat_poll_r;
  logic                rb_sync;
  logic                start_r;
  nrf_pkg::nrf_cycle_t cyc_r;
  logic                cyc_done;
  logic [7:0]          cyc_rdata;
  logic                cle_w;
  logic                ale_w;
  logic                we_n_w;
  logic                re_n_w;
  logic [7:0]          io_w;
  logic                oe_w;
  logic                acc_r;

  // Returns one byte of a four-byte parameter word, first parameter in the low byte.
  function automatic logic [7:0] param_byte(input logic [31:0] w, input logic [1:0] i);
    param_byte = w[8*i +: 8];
  endfunction

  // Keeps only the strength field for usable feature addresses; reserved bits read as zero.
  function automatic logic [31:0] mask_param(input logic [7:0] a, input logic [31:0] w);
    mask_param = 32'h0000_0000;
    if (a == nrf_pkg::FEAT_DRIVE || a == nrf_pkg::FEAT_PULLDOWN)
      mask_param[nrf_pkg::STRENGTH_LSB +: nrf_pkg::STRENGTH_W] =
        w[nrf_pkg::STRENGTH_LSB +: nrf_pkg::STRENGTH_W];
  endfunction

  nrf_sync #(.W(1)) u_rb_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_async   (i_ready_busy_n),
    .o_sync    (rb_sync)
  );

  nrf_cycle u_cycle (
    .i_sys_clk       (i_sys_clk),
    .i_rst           (i_rst),
    .i_ce            (i_ce),
    .i_start         (start_r),
    .i_cyc           (cyc_r),
    .o_done          (cyc_done),
    .o_rdata         (cyc_rdata),
    .o_cle           (cle_w),
    .o_ale           (ale_w),
    .o_we_n          (we_n_w),
    .o_read_strobe_n (re_n_w),
    .o_io_out        (io_w),
    .o_io_oe         (oe_w),
    .i_io_in         (i_io_in)
  );

  // Avalon slave: reads and writes both drop waitrequest, and complete, one cycle after the request.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_r             <= 1'b0;
      o_avs_readdata    <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end
    else if (i_ce)
    begin
      o_avs_waitrequest <= 1'b1;
      acc_r             <= 1'b0;
      if ((i_avs_read || i_avs_write) && !acc_r)
      begin
        acc_r             <= 1'b1;
        o_avs_waitrequest <= 1'b0;
        case (i_avs_address)
          nrf_pkg::REG_CTRL:      o_avs_readdata <= {28'h0, wp_level_r, op_r, 1'b0};
          nrf_pkg::REG_STATUS:    o_avs_readdata <= {29'h0, rb_sync, done_r, busy_r};
          nrf_pkg::REG_FEAT_ADDR: o_avs_readdata <= {24'h0, feat_addr_r};
          nrf_pkg::REG_WDATA:     o_avs_readdata <= wdata_r;
          nrf_pkg::REG_RDATA:     o_avs_readdata <= rdata_r;
          nrf_pkg::REG_NAND_SR:   o_avs_readdata <= {24'h0, nand_sr_r};
          default:                o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes and the command sequencer share state, so one process owns both.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r        <= S_IDLE;
      op_r        <= nrf_pkg::OP_RESET;
      wp_level_r  <= 1'b0;
      feat_addr_r <= nrf_pkg::FEAT_DRIVE;
      wdata_r     <= 32'h0000_0000;
      rdata_r     <= 32'h0000_0000;
      nand_sr_r   <= 8'h00;
      idx_r       <= 2'h0;
      wait_r      <= 8'h00;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      stat_poll_r <= 1'b0;
      start_r     <= 1'b0;
      cyc_r       <= '0;
      o_ce_n      <= 1'b1;
      o_wp_n      <= 1'b0;
    end
    else if (i_ce)
    begin
      start_r <= 1'b0;
      if (i_avs_write && !acc_r && !busy_r)
      begin
        case (i_avs_address)
          nrf_pkg::REG_CTRL:
          begin
            if (i_avs_byteenable[0])
            begin
              op_r       <= i_avs_writedata[nrf_pkg::CTRL_OP_LSB +: 2];
              wp_level_r <= i_avs_writedata[nrf_pkg::CTRL_WP_BIT];
              if (i_avs_writedata[nrf_pkg::CTRL_GO_BIT])
              begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
                idx_r  <= 2'h0;
                // Write-protect changes only while idle, so it stays steady per operation.
                wait_r <= 8'(nrf_pkg::PROTECT_CYC);
                st_r   <= S_WP;
              end
            end
          end
          nrf_pkg::REG_FEAT_ADDR:
            if (i_avs_byteenable[0])
              feat_addr_r <= i_avs_writedata[7:0];
          nrf_pkg::REG_WDATA:
            for (int b = 0; b < 4; b++)
              if (i_avs_byteenable[b])
                wdata_r[8*b +: 8] <= i_avs_writedata[8*b +: 8];
          default:
          begin
          end
        endcase
      end
      else if (i_avs_write && !acc_r && i_avs_address == nrf_pkg::REG_CTRL &&
               i_avs_byteenable[0] && i_avs_writedata[nrf_pkg::CTRL_GO_BIT] &&
               i_avs_writedata[nrf_pkg::CTRL_OP_LSB +: 2] == nrf_pkg::OP_RESET)
      begin
        // A reset may be launched while busy to abort the running operation.
        // Done stays low, so results of the aborted transfer are never reported.
        op_r   <= nrf_pkg::OP_RESET;
        idx_r  <= 2'h0;
        wait_r <= 8'h00;
        st_r   <= S_WP;
      end
      case (st_r)
        S_IDLE:
          o_wp_n <= wp_level_r;
        S_WP:
        begin
          o_ce_n <= 1'b0;
          // Protect takes the level just written, a full setup time before the command unless a reset aborts a running operation.
          o_wp_n <= wp_level_r;
          if (wait_r != 8'h00)
            wait_r <= wait_r - 8'h01;
          else
          begin
            // Only reset, feature, status and read-mode 00h codes are sent; the one-time area is never touched.
            case (op_r)
              nrf_pkg::OP_GET:    cyc_r <= '{cle: 1'b1, ale: 1'b0, rd: 1'b0,
                                             data: nrf_pkg::CMD_GET_FEAT};
              nrf_pkg::OP_SET:    cyc_r <= '{cle: 1'b1, ale: 1'b0, rd: 1'b0,
                                             data: nrf_pkg::CMD_SET_FEAT};
              nrf_pkg::OP_STATUS: cyc_r <= '{cle: 1'b1, ale: 1'b0, rd: 1'b0,
                                             data: nrf_pkg::CMD_STATUS};
              default:            cyc_r <= '{cle: 1'b1, ale: 1'b0, rd: 1'b0,
                                             data: nrf_pkg::CMD_RESET};
            endcase
            start_r <= 1'b1;
            st_r    <= S_CMD;
          end
        end
        S_CMD:
          if (cyc_done)
          begin
            if (op_r == nrf_pkg::OP_GET || op_r == nrf_pkg::OP_SET)
            begin
              // One address cycle follows each feature command.
              cyc_r   <= '{cle: 1'b0, ale: 1'b1, rd: 1'b0, data: feat_addr_r};
              start_r <= 1'b1;
              st_r    <= S_ADDR;
            end
            else if (op_r == nrf_pkg::OP_STATUS)
            begin
              cyc_r   <= '{cle: 1'b0, ale: 1'b0, rd: 1'b1, data: 8'h00};
              start_r <= 1'b1;
              st_r    <= S_STATUS;
            end
            else
            begin
              wait_r <= 8'(nrf_pkg::BUSY_WAIT_CYC);
              st_r   <= S_WAIT_LO;
            end
          end
        S_ADDR:
          if (cyc_done)
          begin
            if (op_r == nrf_pkg::OP_SET)
            begin
              cyc_r   <= '{cle: 1'b0, ale: 1'b0, rd: 1'b0,
                           data: param_byte(mask_param(feat_addr_r, wdata_r), 2'h0)};
              start_r <= 1'b1;
              st_r    <= S_WDATA;
            end
            else
            begin
              wait_r <= 8'(nrf_pkg::BUSY_WAIT_CYC);
              st_r   <= S_WAIT_LO;
            end
          end
        S_WDATA:
          if (cyc_done)
          begin
            if (idx_r == 2'(nrf_pkg::FEAT_BYTES - 1))
            begin
              wait_r <= 8'(nrf_pkg::BUSY_WAIT_CYC);
              st_r   <= S_WAIT_LO;
            end
            else
            begin
              // Four parameter bytes, one per write strobe.
              idx_r   <= idx_r + 2'h1;
              cyc_r   <= '{cle: 1'b0, ale: 1'b0, rd: 1'b0,
                           data: param_byte(mask_param(feat_addr_r, wdata_r), idx_r + 2'h1)};
              start_r <= 1'b1;
            end
          end
        S_WAIT_LO:
        begin
          // Busy may start late; give up waiting for it after the window closes.
          if (!rb_sync || wait_r == 8'h00)
            st_r <= S_WAIT_HI;
          else
            wait_r <= wait_r - 8'h01;
        end
        S_WAIT_HI:
          if (rb_sync)
          begin
            if (op_r == nrf_pkg::OP_GET && stat_poll_r)
            begin
              // Return to data output after a status poll.
              cyc_r       <= '{cle: 1'b1, ale: 1'b0, rd: 1'b0,
                               data: nrf_pkg::CMD_READ_MODE};
              start_r     <= 1'b1;
              stat_poll_r <= 1'b0;
              st_r        <= S_RESUME;
            end
            else if (op_r == nrf_pkg::OP_GET)
            begin
              cyc_r   <= '{cle: 1'b0, ale: 1'b0, rd: 1'b1, data: 8'h00};
              start_r <= 1'b1;
              st_r    <= S_RDATA;
            end
            else
            begin
              // Feature values persist in the device; nothing is reloaded after reset.
              if (op_r == nrf_pkg::OP_RESET)
                nand_sr_r <= wp_level_r ? nrf_pkg::SR_RST_WP_HI
                                        : nrf_pkg::SR_RST_WP_LO;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              o_ce_n <= 1'b1;
              st_r   <= S_IDLE;
            end
          end
        S_RESUME:
          if (cyc_done)
          begin
            cyc_r   <= '{cle: 1'b0, ale: 1'b0, rd: 1'b1, data: 8'h00};
            start_r <= 1'b1;
            st_r    <= S_RDATA;
          end
        S_RDATA:
          if (cyc_done)
          begin
            rdata_r[8*idx_r +: 8] <= cyc_rdata;
            if (idx_r == 2'(nrf_pkg::FEAT_BYTES - 1))
            begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
              o_ce_n <= 1'b1;
              st_r   <= S_IDLE;
            end
            else
            begin
              idx_r   <= idx_r + 2'h1;
              start_r <= 1'b1;
            end
          end
        S_STATUS:
          if (cyc_done)
          begin
            // Bit 6 is ready and bit 0 pass or fail once ready.
            nand_sr_r <= cyc_rdata;
            if (op_r == nrf_pkg::OP_STATUS)
              stat_poll_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            o_ce_n <= 1'b1;
            st_r   <= S_IDLE;
          end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // Pins leave through flip-flops.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cle           <= 1'b0;
      o_ale           <= 1'b0;
      o_we_n          <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_io_out        <= 8'h00;
      o_io_oe         <= 1'b0;
    end
    else if (i_ce)
    begin
      o_cle           <= cle_w;
      o_ale           <= ale_w;
      o_we_n          <= we_n_w;
      o_read_strobe_n <= re_n_w;
      o_io_out        <= io_w;
      o_io_oe         <= oe_w;
    end
  end
endmodule

// ==== nrf_ctrl_sva.sv ====
// Port assertions for the NAND feature and reset host controller.
`timescale 1ns/100ps
module nrf_ctrl_sva (
  // Clock and reset.
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  // Pins.
  input wire logic       o_ce_n,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_we_n,
  input wire logic       o_read_strobe_n,
  input wire logic       o_wp_n,
  input wire logic [7:0] o_io_out,
  input wire logic       o_io_oe
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_we_low;
    (!o_we_n)[*4] ##1 o_we_n;
  endsequence
  sequence s_re_low;
    (!o_read_strobe_n)[*4] ##1 o_read_strobe_n;
  endsequence
  sequence s_feat_cmd;
    o_cle && $rose(o_we_n) && (o_io_out == 8'hee || o_io_out == 8'hef);
  endsequence
  AST_WE_PULSE:
    assert property ($fell(o_we_n) |-> s_we_low) else $error("write strobe width wrong");
  AST_IO_HELD:
    assert property (!o_we_n && $past(!o_we_n) |-> $stable(o_io_out) && $stable(o_cle))
    else $error("bus moved under write strobe");
  AST_WR_DRIVEN:
    assert property (!o_we_n |-> o_io_oe && !(o_cle && o_ale)) else $error("bad write cycle");
  AST_ADDR_NEXT:
    assert property (s_feat_cmd |-> ##[4:12] (o_ale && $fell(o_we_n)))
    else $error("feature address missing");
  AST_RE_PULSE:
    assert property ($fell(o_read_strobe_n) |-> s_re_low) else $error("read strobe width wrong");
  AST_RE_INPUT:
    assert property (!o_read_strobe_n |-> !o_io_oe && !o_cle && !o_ale)
    else $error("bus driven during read");
  AST_WP_HELD:
    assert property (!o_ce_n && $past(!o_ce_n) |-> $stable(o_wp_n)) else $error("protect moved");
  AST_WP_SETUP:
    assert property ($fell(o_ce_n) |-> (o_we_n && o_read_strobe_n)[*8])
    else $error("protect setup short");
endmodule
bind nrf_ctrl nrf_ctrl_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
  .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_wp_n(o_wp_n),
  .o_io_out(o_io_out), .o_io_oe(o_io_oe));

// ==== nrf_nand_model.sv ====
// Behavioural NAND memory for the reset, feature and status commands.
`timescale 1ns/100ps
module nrf_nand_model #(
  parameter int BUSY_CYC = 20
) (
  // Clock.
  input  wire logic               i_sys_clk,
  // Pins.
  input  wire nrf_pkg::nrf_pins_t i_pins,
  output logic [7:0]              o_io_in,
  output logic                    o_ready_busy_n
);
  logic [7:0] feat_r [2][4] = '{default: 8'h00};
  logic [7:0] mode_r = 8'h00;
  logic [7:0] addr_r = 8'h00;
  logic [7:0] val;
  logic [2:0] cnt_r = 3'h0;
  logic       stat_r = 1'b0;
  logic       we_q = 1'b1;
  logic       re_q = 1'b1;
  logic       re_q2 = 1'b1;
  logic       lat;
  logic       hit;
  int         busy_r = 0;
  assign lat = !i_pins.ce_n && i_pins.we_n && !we_q;
  assign hit = addr_r[7:1] == 7'h40;
  assign val = stat_r ? {i_pins.wp_n, {2{busy_r == 0}}, 5'h00} :
    (hit ? feat_r[addr_r[0]][cnt_r[1:0]] : 8'h00);
  // Released or busy bus shows the inverse so a stale sample cannot match.
  assign o_io_in = (i_pins.ce_n || busy_r != 0) ? ~val : val;
  assign o_ready_busy_n = busy_r == 0;
  always @(posedge i_sys_clk)
  begin
    we_q <= i_pins.we_n;
    re_q <= i_pins.read_strobe_n;
    re_q2 <= re_q;
    if (busy_r != 0)
      busy_r <= busy_r - 1;
    if (lat && i_pins.cle)
    begin
      mode_r <= i_pins.io_out;
      cnt_r <= 3'h0;
      stat_r <= i_pins.io_out == 8'h70 ||
        (stat_r && i_pins.io_out != 8'h00 && i_pins.io_out != 8'hff);
      if (i_pins.io_out == 8'hff)
        busy_r <= BUSY_CYC;
    end
    else if (lat && i_pins.ale)
    begin
      addr_r <= i_pins.io_out;
      cnt_r <= 3'h0;
      if (mode_r == 8'hee)
        busy_r <= BUSY_CYC;
    end
    else if (lat && mode_r == 8'hef)
    begin
      if (hit)
        feat_r[addr_r[0]][cnt_r[1:0]] <= i_pins.io_out;
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h3)
        busy_r <= BUSY_CYC;
    end
    else if (re_q && !re_q2)
      cnt_r <= cnt_r + 3'h1;
  end
endmodule

// ==== nrf_ctrl_tb.sv ====
// Testbench for the NAND feature and reset host controller.
`timescale 1ns/100ps
module nrf_ctrl_tb;
  logic        clk, rst, rd, wr, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n, wt;
  logic [1:0]  v;
  logic [4:0]  adr;
  logic [7:0]  io_o, io_i, fa;
  logic [31:0] wd, rdat, q;
  int          n_fail, checked, n;
  nrf_ctrl DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_ce_n(ce_n), .o_cle(cle),
    .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n), .o_wp_n(wp_n), .o_io_out(io_o),
    .o_io_oe(oe), .i_io_in(io_i), .i_ready_busy_n(rb_n));
  nrf_nand_model u_nand (
    .i_sys_clk(clk), .i_pins({ce_n, cle, ale, we_n, re_n, wp_n, io_o, oe}),
    .o_io_in(io_i), .o_ready_busy_n(rb_n));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    for (k = 0; k < 50 && (k == 0 || wt !== 1'b0); k++)
      @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wt !== 1'b0)
    begin
      n_fail++;
      finish_test();
    end
    @(posedge clk);
  endtask
  task automatic op(input logic [1:0] o, input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    bus(1'b1, nrf_pkg::REG_FEAT_ADDR, {24'h0, a});
    bus(1'b1, nrf_pkg::REG_WDATA, d);
    bus(1'b1, nrf_pkg::REG_CTRL, {28'h0, w, o, 1'b1});
    q = 32'h0;
    for (k = 0; k < 400 && q[1] !== 1'b1; k++)
      bus(1'b0, nrf_pkg::REG_STATUS, 32'h0);
    if (q[1] !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] e);
    op(nrf_pkg::OP_GET, 1'b1, a, 32'h0);
    bus(1'b0, nrf_pkg::REG_RDATA, 32'h0);
    chk(q, e);
  endtask
  task automatic sr(input logic [7:0] e);
    bus(1'b0, nrf_pkg::REG_NAND_SR, 32'h0);
    chk(q, {24'h0, e});
  endtask
  initial
  begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wd = 32'h0;
    n_fail = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    op(nrf_pkg::OP_RESET, 1'b1, 8'h00, 32'h0);
    sr(8'he0);
    get(8'h80, 32'h0);
    get(8'h81, 32'h0);
    for (int j = 0; j < 8; j++)
    begin
      fa = 8'h80 | 8'(j % 2);
      v = 2'(j / 2) ^ {fa[0], 1'b0};
      op(nrf_pkg::OP_SET, 1'b1, fa, 32'hffff_fffc | 32'(v));
      get(fa, {30'h0, v});
    end
    op(nrf_pkg::OP_RESET, 1'b0, 8'h00, 32'h0);
    sr(8'h60);
    get(8'h80, 32'h3);
    get(8'h81, 32'h1);
    for (int j = 0; j < 2; j++)
    begin
      op(nrf_pkg::OP_SET, 1'b1, 8'h7f | 8'(j * 128), 32'hffff_ffff);
      get(8'h7f | 8'(j * 128), 32'h0);
    end
    op(nrf_pkg::OP_STATUS, 1'b1, 8'h00, 32'h0);
    sr(8'he0);
    get(8'h80, 32'h3);
    bus(1'b1, nrf_pkg::REG_FEAT_ADDR, 32'h80);
    bus(1'b1, nrf_pkg::REG_CTRL, {28'h1, nrf_pkg::OP_GET, 1'b1});
    for (n = 0; n < 300 && rb_n !== 1'b0; n++)
      @(posedge clk);
    if (rb_n !== 1'b0)
    begin
      n_fail++;
      finish_test();
    end
    op(nrf_pkg::OP_RESET, 1'b1, 8'h00, 32'h0);
    sr(8'he0);
    get(8'h81, 32'h1);
    bus(1'b0, 5'h18, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, nrf_pkg::REG_CTRL, 32'h0);
    chk({31'h0, q[0]}, 32'h0);
    bus(1'b0, nrf_pkg::REG_STATUS, 32'h0);
    chk(q, 32'h6);
    finish_test();
  end
endmodule
